// ---- sba_arbiter.sv ----
// secondary bus arbiter with its axi4-lite register slave
`timescale 1ns/1ns
`include "sba_map.svh"
module sba_arbiter
  import sba_pkg::*;
#(
  parameter int N_EXT = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire sba_axil_req_type axil_req_in,
  output sba_axil_rsp_type      axil_rsp_out,
  input  wire logic             int_req_in,
  output logic                  int_gnt_out,
  input  wire logic [N_EXT-1:0] req_l_in,
  output logic      [N_EXT-1:0] gnt_l_out,
  input  wire logic             frame_l_in,
  input  wire logic             irdy_l_in,
  input  wire logic             arbiter_select_strap_in
);

  localparam int NSYNC = N_EXT + 3;

  generate
    if (N_EXT != `SBA_NREQ - 1) begin : g_bad_count
      $error("sba_arbiter serves exactly eight external masters");
    end
  endgenerate

  sba_state_type state_r;
  sba_state_type state_nxt;

  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_sync;
  logic [N_EXT-1:0] req_l_s;
  logic             frame_l_s;
  logic             irdy_l_s;
  logic             strap_s;

  // bus pins come from the secondary clock domain boundary; strap resets low
  assign pins_raw = {arbiter_select_strap_in, irdy_l_in, frame_l_in, req_l_in};

  sba_sync #(
    .W       (NSYNC),
    .RST_VAL (64'h0000_0000_0000_03FF)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .async_in    (pins_raw),
    .sync_out    (pins_sync)
  );

  assign req_l_s   = pins_sync[N_EXT-1:0];
  assign frame_l_s = pins_sync[N_EXT];
  assign irdy_l_s  = pins_sync[N_EXT+1];
  assign strap_s   = pins_sync[N_EXT+2];

  // round robin search starting just after the last owner
  function automatic logic [3:0] rr_pick(input logic [8:0] pool, input logic [3:0] last);
    int         idx;
    logic [3:0] pick;
    logic       found;
    pick  = 4'h0;
    found = 1'b0;
    for (int k = 1; k <= `SBA_NREQ; k++) begin
      idx = (int'(last) + k) % `SBA_NREQ;
      if (!found && pool[idx]) begin
        pick  = 4'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction : rr_pick

  // register read mux; strap bit is refreshed into cfg every cycle
  function automatic logic [31:0] reg_read(input sba_state_type s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (s.rsp.rvalid) begin
      d = s.rsp.rdata;
    end
    return d;
  endfunction : reg_read

  logic [8:0]  req_v;
  logic [8:0]  en_v;
  logic [8:0]  prio_v;
  logic [8:0]  elig_v;
  logic [8:0]  hi_v;
  logic [8:0]  pool_v;
  logic [8:0]  others_v;
  logic [8:0]  own_bit;
  logic [8:0]  live_v;
  logic [7:0]  fair_init;
  logic [3:0]  winner;
  logic        bus_idle;
  logic        frame_fall;
  logic        own_req;
  logic        drop;
  logic        toggle_gap;
  logic        wr_cfg;
  logic [31:0] wmask;
  logic [31:0] rd_addr;

  always_comb begin
    state_nxt  = state_r;
    req_v      = 9'h000;
    en_v       = 9'h000;
    prio_v     = 9'h000;
    elig_v     = 9'h000;
    hi_v       = 9'h000;
    pool_v     = 9'h000;
    others_v   = 9'h000;
    own_bit    = 9'h000;
    live_v     = 9'h000;
    fair_init  = 8'h00;
    winner     = 4'h0;
    own_req    = 1'b0;
    drop       = 1'b0;
    toggle_gap = 1'b0;
    wr_cfg     = 1'b0;
    wmask      = 32'h0000_0000;
    rd_addr    = axil_req_in.araddr;

    // ---------------- axi4-lite write channel ----------------
    if (state_r.rsp.bvalid && axil_req_in.bready) begin
      state_nxt.rsp.bvalid = 1'b0;
    end
    if (axil_req_in.awvalid && state_r.rsp.awready) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = axil_req_in.awaddr;
    end
    if (axil_req_in.wvalid && state_r.rsp.wready) begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = axil_req_in.wdata;
      state_nxt.wstrb = axil_req_in.wstrb;
    end
    if (state_nxt.aw_got && state_nxt.w_got && !state_r.rsp.bvalid) begin
      state_nxt.aw_got     = 1'b0;
      state_nxt.w_got      = 1'b0;
      state_nxt.rsp.bvalid = 1'b1;
      if (state_nxt.awaddr == `SBA_CFG_ADDR) begin
        wr_cfg              = 1'b1;
        state_nxt.rsp.bresp = `SBA_RESP_OKAY;
      end else if (state_nxt.awaddr == `SBA_STAT_ADDR) begin
        // status is read only; write is accepted and dropped
        state_nxt.rsp.bresp = `SBA_RESP_OKAY;
      end else begin
        state_nxt.rsp.bresp = `SBA_RESP_SLVERR;
      end
    end
    if (wr_cfg) begin
      for (int b = 0; b < 4; b++) begin
        if (state_nxt.wstrb[b]) begin
          wmask[b*8 +: 8] = 8'hFF;
        end
      end
      // read only and reserved bits never take a write
      wmask         = wmask & `SBA_CFG_WMASK;
      state_nxt.cfg = (state_nxt.wdata & wmask) | (state_r.cfg & ~wmask);
    end
    state_nxt.cfg[`SBA_STRAP_BIT] = strap_s;
    state_nxt.rsp.awready = !state_nxt.aw_got && !state_nxt.rsp.bvalid;
    state_nxt.rsp.wready  = !state_nxt.w_got && !state_nxt.rsp.bvalid;

    // ---------------- axi4-lite read channel ----------------
    if (state_r.rsp.rvalid && axil_req_in.rready) begin
      state_nxt.rsp.rvalid = 1'b0;
    end
    if (axil_req_in.arvalid && state_r.rsp.arready) begin
      state_nxt.rsp.rvalid = 1'b1;
      if (rd_addr == `SBA_CFG_ADDR) begin
        state_nxt.rsp.rdata = state_r.cfg;
        state_nxt.rsp.rresp = `SBA_RESP_OKAY;
      end else if (rd_addr == `SBA_STAT_ADDR) begin
        state_nxt.rsp.rdata = {7'h00, state_r.served, state_r.broken, 2'h0,
                               state_r.st == SBA_ST_GRANT, state_r.owner};
        state_nxt.rsp.rresp = `SBA_RESP_OKAY;
      end else begin
        state_nxt.rsp.rdata = 32'h0000_0000;
        state_nxt.rsp.rresp = `SBA_RESP_SLVERR;
      end
    end
    state_nxt.rsp.arready = !state_nxt.rsp.rvalid;

    // ---------------- request conditioning ----------------
    // new enables act in the same edge they are written, so a disabled
    // master loses its grant without a stale cycle
    req_v     = {~req_l_s, int_req_in};
    en_v      = state_nxt.cfg[`SBA_EN_MSB:`SBA_EN_LSB];
    prio_v    = state_r.cfg[`SBA_PRIO_MSB:`SBA_PRIO_LSB];
    fair_init = state_r.cfg[`SBA_FAIR_MSB:`SBA_FAIR_LSB];
    elig_v    = req_v & en_v & ~state_r.broken;
    hi_v      = elig_v & prio_v;
    pool_v    = (|hi_v) ? hi_v : elig_v;
    winner    = rr_pick(pool_v, state_r.owner);
    own_bit   = 9'h001 << state_r.owner;
    others_v  = elig_v & ~own_bit;
    own_req   = |(req_v & en_v & own_bit);
    bus_idle   = frame_l_s && irdy_l_s;
    frame_fall = state_r.frame_prev && !frame_l_s;
    state_nxt.frame_prev = frame_l_s;

    // refresh: a broken master returns once all live others were served
    live_v = en_v & ~state_r.broken;
    for (int i = 0; i < `SBA_NREQ; i++) begin
      if (state_r.broken[i] && state_r.cfg[`SBA_REFR_BIT] &&
          ((live_v & ~(9'h001 << i) & ~state_r.served) == 9'h000)) begin
        state_nxt.broken[i] = 1'b0;
      end
    end
    if (live_v != 9'h000 && (live_v & ~state_r.served) == 9'h000) begin
      state_nxt.served = 9'h000;
    end

    // ---------------- arbitration ----------------
    case (state_r.st)
      SBA_ST_IDLE: begin
        // strap high hands the bus to an external arbiter
        if (!strap_s && |elig_v) begin
          state_nxt.st              = SBA_ST_GRANT;
          state_nxt.owner           = winner;
          state_nxt.fair_cnt        = fair_init;
          state_nxt.armed           = 1'b0;
          state_nxt.bm_cnt          = 5'h00;
          state_nxt.tog_cnt         = 2'h0;
          state_nxt.served[winner]  = 1'b1;
        end
      end
      SBA_ST_GRANT: begin
        if (frame_fall && !state_r.armed) begin
          state_nxt.armed   = 1'b1;
          state_nxt.tog_cnt = 2'h1;
        end else if (state_r.tog_cnt != 2'h0 && state_r.tog_cnt != `SBA_TOG_DONE) begin
          state_nxt.tog_cnt = state_r.tog_cnt + 2'h1;
        end
        // broken master watch runs only until the first frame is seen
        if (state_r.cfg[`SBA_BMTO_BIT] && !state_r.armed && !frame_fall && bus_idle) begin
          state_nxt.bm_cnt = state_r.bm_cnt + 5'h01;
          if (state_nxt.bm_cnt == `SBA_BMTO_CYCLES) begin
            // set here wins over any refresh clear in the same cycle
            state_nxt.broken[state_r.owner] = 1'b1;
            state_nxt.served                = 9'h000;
            drop                            = 1'b1;
          end
        end
        if (!own_req) begin
          drop = 1'b1;
        end
        if (state_r.armed && |others_v && fair_init != 8'h00) begin
          state_nxt.fair_cnt = state_r.fair_cnt - 8'h01;
          if (state_r.fair_cnt <= 8'h01) begin
            drop = 1'b1;
          end
        end
        if (strap_s) begin
          drop = 1'b1;
        end
        if (drop) begin
          // one idle cycle between owners keeps grants exclusive
          state_nxt.st      = SBA_ST_IDLE;
          state_nxt.tog_cnt = 2'h0;
        end
      end
      default: begin
        state_nxt.st = SBA_ST_IDLE;
      end
    endcase

    // ---------------- grant outputs ----------------
    toggle_gap = state_r.cfg[`SBA_TOG_BIT] && state_nxt.tog_cnt == `SBA_TOG_DELAY;
    state_nxt.int_gnt   = 1'b0;
    state_nxt.ext_gnt_l = 8'hFF;
    if (state_nxt.st == SBA_ST_GRANT && !toggle_gap) begin
      if (state_nxt.owner == 4'h0) begin
        state_nxt.int_gnt = 1'b1;
      end else begin
        state_nxt.ext_gnt_l = ~(8'h01 << (state_nxt.owner - 4'h1));
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r             <= '0;
      state_r.st          <= SBA_ST_IDLE;
      state_r.cfg         <= `SBA_CFG_RST;
      state_r.frame_prev  <= 1'b1;
      state_r.ext_gnt_l   <= 8'hFF;
      state_r.rsp.awready <= 1'b1;
      state_r.rsp.wready  <= 1'b1;
      state_r.rsp.arready <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign axil_rsp_out = state_r.rsp;
  assign int_gnt_out  = state_r.int_gnt;
  assign gnt_l_out    = state_r.ext_gnt_l;

endmodule : sba_arbiter

// ---- sba_map.svh ----
// register map, field positions, reset values and timing counts of the secondary bus arbiter
// Functional notes
// - bit 0 enables internal bridge request, resets 1
// - bits 1-8 enable external masters, reset 1
// - bit 9 reads arbiter select strap level
// - timeout enable counts 16 idle granted cycles
// - timeout expiry removes grant from that master
// - refresh off: broken master ignored for good
// - refresh on: clear broken after others served
// - bits 19:12 fairness initial value, reset 08h
// - hold grant fairness cycles after rival request
// - reload fairness counter on every new grant
// - counter arms at next falling frame edge
// - fairness 00h: keep grant until request withdrawn
// - toggle off: grant stays after frame asserted
// - toggle on: grant off one clock, two after
// - bits 22-30 priority, internal high, others low
`ifndef SBA_MAP_SVH
`define SBA_MAP_SVH

`define SBA_NREQ          9
`define SBA_CFG_ADDR      32'h0000_0048
`define SBA_STAT_ADDR     32'h0000_0080
`define SBA_CFG_RST       32'h0040_81FF
`define SBA_CFG_WMASK     32'h7FDF_FDFF
`define SBA_EN_LSB        0
`define SBA_EN_MSB        8
`define SBA_STRAP_BIT     9
`define SBA_BMTO_BIT      10
`define SBA_REFR_BIT      11
`define SBA_FAIR_LSB      12
`define SBA_FAIR_MSB      19
`define SBA_TOG_BIT       20
`define SBA_PRIO_LSB      22
`define SBA_PRIO_MSB      30
`define SBA_BMTO_CYCLES   5'h10
`define SBA_TOG_DELAY     2'h2
`define SBA_TOG_DONE      2'h3
`define SBA_RESP_OKAY     2'h0
`define SBA_RESP_SLVERR   2'h2

`endif

// ---- sba_pkg.sv ----
// types shared by the secondary bus arbiter files
package sba_pkg;

  typedef enum logic [0:0] {
    SBA_ST_IDLE  = 1'h0,
    SBA_ST_GRANT = 1'h1
  } sba_arb_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } sba_axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sba_axil_rsp_type;

  typedef struct packed {
    sba_arb_state_type st;
    logic [31:0]       cfg;
    logic [3:0]        owner;
    logic [8:0]        broken;
    logic [8:0]        served;
    logic [7:0]        fair_cnt;
    logic              armed;
    logic [4:0]        bm_cnt;
    logic [1:0]        tog_cnt;
    logic              frame_prev;
    logic              int_gnt;
    logic [7:0]        ext_gnt_l;
    logic              aw_got;
    logic              w_got;
    logic [31:0]       awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    sba_axil_rsp_type  rsp;
  } sba_state_type;

endpackage : sba_pkg

// ---- sba_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module sba_sync #(
  parameter int          W       = 1,
  parameter logic [63:0] RST_VAL = 64'hFFFF_FFFF_FFFF_FFFF
) (
  input  wire logic         core_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sba_sync_state_type;

  sba_sync_state_type state_r;
  sba_sync_state_type state_nxt;

  generate
    if (W < 1 || W > 64) begin : g_bad_width
      $error("sba_sync width out of range");
    end
  endgenerate

  // first stage feeds only the second stage
  always_comb begin
    state_nxt    = state_r;
    state_nxt.s1 = async_in;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= {RST_VAL[W-1:0], RST_VAL[W-1:0]};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.s2;

endmodule : sba_sync

// ---- sba_masters_model.sv ----
// behavioural secondary bus masters: request, frame and ready pins
`timescale 1ns/1ns
module sba_masters_model (
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] want_in,
  input  wire logic [7:0] dead_in,
  input  wire logic [7:0] gnt_l_in,
  output logic      [7:0] req_l_out,
  output logic            frame_l_out,
  output logic            irdy_l_out
);
  logic [7:0] done_r;
  logic [5:0] left_r;
  assign req_l_out   = ~want_in;
  // released bus lines sit at their pull-up level
  assign frame_l_out = (left_r == 6'h00);
  assign irdy_l_out  = frame_l_out;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_r <= 8'h00;
      left_r <= 6'h00;
    end else begin
      done_r <= done_r & want_in;
      if (left_r != 6'h00) begin
        left_r <= left_r - 6'h01;
      end else if ((~gnt_l_in & want_in & ~dead_in & ~done_r) != 8'h00) begin
        // one frame per request, so a toggled grant does not start another
        left_r <= 6'h14;
        done_r <= (done_r | ~gnt_l_in) & want_in;
      end
    end
  end
endmodule : sba_masters_model

// ---- sba_arbiter_asserts.sv ----
// concurrent checks on the secondary bus arbiter ports
`timescale 1ns/1ns
module sba_arbiter_asserts
  import sba_pkg::*;
#(
  parameter int N_EXT = 8
) (
  input wire logic             core_clk_in,
  input wire logic             arst_n_in,
  input wire sba_axil_req_type axil_req_in,
  input wire sba_axil_rsp_type axil_rsp_out,
  input wire logic             int_req_in,
  input wire logic             int_gnt_out,
  input wire logic [N_EXT-1:0] req_l_in,
  input wire logic [N_EXT-1:0] gnt_l_out,
  input wire logic             frame_l_in,
  input wire logic             irdy_l_in,
  input wire logic             arbiter_select_strap_in
);
  logic [N_EXT:0] gv;
  logic           aw_w;
  assign gv   = {~gnt_l_out, int_gnt_out};
  assign aw_w = axil_req_in.awvalid && axil_rsp_out.awready && axil_req_in.wvalid && axil_rsp_out.wready;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // strap passes a two stage synchroniser before it blocks grants
  sequence s_strap_held;
    arbiter_select_strap_in [*5];
  endsequence
  sequence s_new_ext;
    (gv == '0) ##1 (gnt_l_out != '1);
  endsequence
  chk_one_grant: assert property ($onehot0(gv))
    else $error("two grants at once");
  chk_strap_blocks: assert property (s_strap_held |-> gv == '0)
    else $error("grant while external arbiter selected");
  chk_int_cause: assert property ($rose(int_gnt_out) |-> $past(int_req_in))
    else $error("internal grant without request");
  chk_ext_cause: assert property (s_new_ext |->
    (~gnt_l_out & ~($past(req_l_in, 2) & $past(req_l_in, 3))) != '0)
    else $error("external grant without request");
  chk_no_handover: assert property (gv != '0 && gv != $past(gv) |-> $past(gv) == '0)
    else $error("grant moved without an idle cycle");
  chk_rd_answer: assert property (axil_req_in.arvalid && axil_rsp_out.arready |=>
    axil_rsp_out.rvalid && !axil_rsp_out.arready)
    else $error("read not answered next cycle");
  chk_rd_release: assert property (axil_rsp_out.rvalid && axil_req_in.rready |=>
    !axil_rsp_out.rvalid && axil_rsp_out.arready)
    else $error("read answer not released");
  chk_wr_answer: assert property (aw_w |=> axil_rsp_out.bvalid && !axil_rsp_out.awready && !axil_rsp_out.wready)
    else $error("write not answered next cycle");
  chk_wr_release: assert property (axil_rsp_out.bvalid && axil_req_in.bready |=>
    !axil_rsp_out.bvalid && axil_rsp_out.awready && axil_rsp_out.wready)
    else $error("write answer not released");
endmodule : sba_arbiter_asserts
bind sba_arbiter sba_arbiter_asserts #(.N_EXT(N_EXT)) u_chk (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .axil_req_in(axil_req_in), .axil_rsp_out(axil_rsp_out), .int_req_in(int_req_in), .int_gnt_out(int_gnt_out),
  .req_l_in(req_l_in), .gnt_l_out(gnt_l_out), .frame_l_in(frame_l_in), .irdy_l_in(irdy_l_in),
  .arbiter_select_strap_in(arbiter_select_strap_in));

// ---- tb_secondary_bus_arbiter.sv ----
// self-checking bench for the secondary bus arbiter
`timescale 1ns/1ns
`include "sba_map.svh"
module tb_secondary_bus_arbiter
  import sba_pkg::*;
;
  logic             core_clk;
  logic             arst_n;
  sba_axil_req_type req;
  sba_axil_rsp_type rsp;
  logic             int_req;
  logic             int_gnt;
  logic [7:0]       req_l;
  logic [7:0]       gnt_l;
  logic             frame_l;
  logic             irdy_l;
  logic             strap;
  logic [7:0]       want;
  logic [7:0]       dead;
  logic [8:0]       gv;
  logic [31:0]      rv;
  logic [1:0]       rr;
  int               n_fail;
  int               checks;
  int               i;
  int               n;
  int               d[3];
  assign gv = {~gnt_l, int_gnt};
  sba_arbiter DUT (.core_clk_in(core_clk), .arst_n_in(arst_n), .axil_req_in(req), .axil_rsp_out(rsp),
    .int_req_in(int_req), .int_gnt_out(int_gnt), .req_l_in(req_l), .gnt_l_out(gnt_l), .frame_l_in(frame_l),
    .irdy_l_in(irdy_l), .arbiter_select_strap_in(strap));
  sba_masters_model u_mst (.core_clk_in(core_clk), .arst_n_in(arst_n), .want_in(want), .dead_in(dead),
    .gnt_l_in(gnt_l), .req_l_out(req_l), .frame_l_out(frame_l), .irdy_l_out(irdy_l));
  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tmo(input int c);
    if (c >= 200) begin
      n_fail++;
      results();
    end
  endtask : tmo
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    int c;
    c = 0;
    req.awvalid <= 1'h1;
    req.awaddr  <= a;
    req.wvalid  <= 1'h1;
    req.wdata   <= v;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'h1;
    do begin
      @(posedge core_clk);
      c++;
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (!rsp.bvalid && c < 200);
    tmo(c);
    chk(rsp.bresp, `SBA_RESP_OKAY, "bresp");
    req.bready <= 1'h0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
    int c;
    c = 0;
    req.arvalid <= 1'h1;
    req.araddr  <= a;
    req.rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      c++;
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (!rsp.rvalid && c < 200);
    tmo(c);
    rv = rsp.rdata;
    rr = rsp.rresp;
    if (e !== 32'hFFFF_FFFF) chk(rv, e, nm);
    chk(rr, er, nm);
    req.rready <= 1'h0;
    @(posedge core_clk);
  endtask : rdc
  // fields placed as the mode register lays them out, priorities at reset
  task automatic set_cfg(input logic [8:0] en, input logic [2:0] fl, input logic [7:0] fair);
    wr(`SBA_CFG_ADDR, {1'h0, 9'h001, 1'h0, fl[2], fair, fl[1], fl[0], 1'h0, en});
  endtask : set_cfg
  task automatic wait_on(input int k, input logic lvl, input int lim, output int c);
    c = 0;
    while (gv[k] !== lvl && c < lim) begin
      @(posedge core_clk);
      c++;
    end
  endtask : wait_on
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    arst_n  = 1'h0;
    req     = '0;
    int_req = 1'h0;
    strap   = 1'h0;
    want    = 8'h00;
    dead    = 8'h00;
    n_fail  = 0;
    checks  = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'h1;
    @(posedge core_clk);
    rdc(`SBA_CFG_ADDR, 32'h0040_81FF, `SBA_RESP_OKAY, "cfg_reset");
    wr(`SBA_CFG_ADDR, 32'hFFFF_FFFF);
    rdc(`SBA_CFG_ADDR, 32'h7FDF_FDFF, `SBA_RESP_OKAY, "cfg_ro_bits");
    rdc(32'h0000_0060, 32'h0000_0000, `SBA_RESP_SLVERR, "unmapped");
    set_cfg(9'h1FF, 3'h0, 8'h08);
    strap   <= 1'h1;
    int_req <= 1'h1;
    repeat (30) @(posedge core_clk);
    chk(gv, 9'h000, "strap_grant");
    rdc(`SBA_CFG_ADDR, 32'h0040_83FF, `SBA_RESP_OKAY, "strap_bit");
    strap <= 1'h0;
    wait_on(0, 1'h1, 20, n);
    chk(n < 20, 1'h1, "int_grant");
    set_cfg(9'h1FE, 3'h0, 8'h08);
    repeat (10) @(posedge core_clk);
    chk(gv, 9'h000, "int_disabled");
    int_req <= 1'h0;
    for (i = 1; i <= 8; i++) begin
      set_cfg(9'h1FF & ~(9'h001 << i), 3'h0, 8'h08);
      want <= 8'h01 << (i - 1);
      repeat (12) @(posedge core_clk);
      chk(gv, 9'h000, "ext_disabled");
      set_cfg(9'h1FF, 3'h0, 8'h08);
      wait_on(i, 1'h1, 12, n);
      chk(n < 12, 1'h1, "ext_enabled");
      want <= 8'h00;
      repeat (30) @(posedge core_clk);
    end
    for (i = 0; i < 2; i++) begin
      set_cfg(9'h1FF, {i[0], 2'h0}, 8'h08);
      want <= 8'h01;
      wait_on(1, 1'h1, 20, n);
      n = 0;
      repeat (30) begin
        @(posedge core_clk);
        n += (gv[1] === 1'h0);
      end
      chk(n, i, "toggle_gap");
      want <= 8'h00;
      repeat (30) @(posedge core_clk);
    end
    // grant lengths differ only by the fairness value, so sync delays cancel
    for (i = 0; i < 3; i++) begin
      set_cfg(9'h1FF, 3'h0, (i == 2) ? 8'h00 : (8'h08 >> i));
      want <= 8'h01;
      wait_on(1, 1'h1, 20, n);
      want <= 8'h05;
      wait_on(1, 1'h0, 100, d[i]);
      want <= 8'h00;
      // every holder must let go once its request is withdrawn
      repeat (10) @(posedge core_clk);
      chk(gv, 9'h000, "grant_release");
      repeat (40) @(posedge core_clk);
    end
    chk(d[0] - d[1], 4, "fair_span");
    chk(d[2], 100, "fair_zero");
    set_cfg(9'h006, 3'h1, 8'h08);
    dead <= 8'h02;
    want <= 8'h02;
    wait_on(2, 1'h1, 20, n);
    wait_on(2, 1'h0, 40, n);
    chk(n >= 16 && n <= 17, 1'h1, "bm_timeout");
    repeat (30) @(posedge core_clk);
    chk(gv[2], 1'h0, "broken_ignored");
    rdc(`SBA_STAT_ADDR, 32'hFFFF_FFFF, `SBA_RESP_OKAY, "status");
    chk(rv[9], 1'h1, "broken_flag");
    set_cfg(9'h006, 3'h3, 8'h08);
    want <= 8'h03;
    wait_on(1, 1'h1, 20, n);
    want <= 8'h02;
    wait_on(2, 1'h1, 60, n);
    chk(n < 60, 1'h1, "broken_refresh");
    want <= 8'h00;
    dead <= 8'h00;
    repeat (20) @(posedge core_clk);
    // master 1 high, internal low; round robin alone would pick master 3 after owner 2
    wr(`SBA_CFG_ADDR, 32'h0080_81FF);
    want <= 8'h05;
    n = 0;
    while (gv === 9'h000 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk(gv, 9'h002, "prio_grant");
    want <= 8'h00;
    repeat (20) @(posedge core_clk);
    results();
  end
endmodule : tb_secondary_bus_arbiter
